// ### stepper_pkg.sv
package stepper_pkg;

  localparam int CLK_FREQ_MHZ = 200;
  localparam int CHOP_FREQ_KHZ = 100;
  localparam int CHOP_DIV_CYCLES = CLK_FREQ_MHZ * 1000 / CHOP_FREQ_KHZ;
  localparam int ISD_MASK_TICKS = 4;

  localparam int ANGLE_W = 7;
  localparam int MAG_W = 8;
  localparam logic [6:0] HOME_ANGLE = 7'h10;
  localparam logic [6:0] QUARTER_TURN = 7'h20;
  localparam logic [7:0] FULL_SCALE = 8'hFF;

  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h04;
  localparam logic CTRL_RESET = 1'b0;
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int ST_ANGLE_LSB = 0;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_STANDBY_BIT = 11;
  localparam int ST_THERMAL_BIT = 12;
  localparam int ST_OVERCURRENT_BIT = 13;
  localparam int ST_HOME_BIT = 14;
  localparam int ST_FAULT_PIN_BIT = 15;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_FULL,
    MODE_HALF_A,
    MODE_QUARTER,
    MODE_HALF_B,
    MODE_EIGHTH,
    MODE_SIXTEENTH,
    MODE_THIRTYSECOND
  } step_mode_t;

endpackage : stepper_pkg

// ### phase_map_if.sv
`timescale 1ns/1ps
interface phase_map_if;
  logic [6:0] angle;
  stepper_pkg::step_mode_t mode;
  logic [7:0] a_mag;
  logic [7:0] b_mag;
  logic a_neg;
  logic b_neg;

  modport requester (
    output angle,
    output mode,
    input a_mag,
    input b_mag,
    input a_neg,
    input b_neg
  );

  modport mapper (
    input angle,
    input mode,
    output a_mag,
    output b_mag,
    output a_neg,
    output b_neg
  );
endinterface : phase_map_if

// ### angle_to_phase.sv
`timescale 1ns/1ps
module angle_to_phase (
  phase_map_if.mapper pm
);

  // quarter-wave sine, 33 points, full scale 255
  function automatic logic [7:0] sine_q(input logic [5:0] k);
    case (k)
      6'h00: sine_q = 8'h00;
      6'h01: sine_q = 8'h0D;
      6'h02: sine_q = 8'h19;
      6'h03: sine_q = 8'h25;
      6'h04: sine_q = 8'h32;
      6'h05: sine_q = 8'h3E;
      6'h06: sine_q = 8'h4A;
      6'h07: sine_q = 8'h56;
      6'h08: sine_q = 8'h62;
      6'h09: sine_q = 8'h6D;
      6'h0A: sine_q = 8'h78;
      6'h0B: sine_q = 8'h83;
      6'h0C: sine_q = 8'h8E;
      6'h0D: sine_q = 8'h98;
      6'h0E: sine_q = 8'hA2;
      6'h0F: sine_q = 8'hAB;
      6'h10: sine_q = 8'hB4;
      6'h11: sine_q = 8'hBD;
      6'h12: sine_q = 8'hC5;
      6'h13: sine_q = 8'hCD;
      6'h14: sine_q = 8'hD4;
      6'h15: sine_q = 8'hDB;
      6'h16: sine_q = 8'hE1;
      6'h17: sine_q = 8'hE7;
      6'h18: sine_q = 8'hEC;
      6'h19: sine_q = 8'hF0;
      6'h1A: sine_q = 8'hF4;
      6'h1B: sine_q = 8'hF7;
      6'h1C: sine_q = 8'hFA;
      6'h1D: sine_q = 8'hFC;
      6'h1E: sine_q = 8'hFE;
      default: sine_q = 8'hFF;
    endcase
  endfunction : sine_q

  function automatic logic [7:0] magnitude(input logic [6:0] idx,
                                           input logic coarse);
    logic [5:0] k;
    logic [7:0] m;
    k = idx[5] ? 6'(6'h20 - {1'b0, idx[4:0]}) : {1'b0, idx[4:0]};
    m = sine_q(k);
    // full and half step drive either zero or full current
    magnitude = (coarse && m != 8'h00) ? stepper_pkg::FULL_SCALE : m;
  endfunction : magnitude

  logic coarse;
  logic [6:0] a_angle;

  always_comb begin
    coarse = (pm.mode == stepper_pkg::MODE_FULL) ||
             (pm.mode == stepper_pkg::MODE_HALF_A) ||
             (pm.mode == stepper_pkg::MODE_HALF_B) ||
             (pm.mode == stepper_pkg::MODE_STANDBY);
    // phase a is a quarter cycle ahead of phase b
    a_angle = 7'(pm.angle + stepper_pkg::QUARTER_TURN);
    pm.a_mag = magnitude(a_angle, coarse);
    pm.b_mag = magnitude(pm.angle, coarse);
    pm.a_neg = a_angle[6];
    pm.b_neg = pm.angle[6];
  end

endmodule : angle_to_phase

// ### stepper_step_dir_control.sv
// Summary of operation
// - enable high drives bridges, low tristates
// - direction selects which phase leads by 90
// - all selects low: standby, chopper and outputs off
// - select code picks full to 1/32 step
// - angle reset input forces home position
// - home is 45 degrees, 100 or 71 percent
// - home monitor low at home position
// - fault pin low on thermal or overcurrent
// - fault pin open drain, external pull-up
// - step clock rising edge advances one step
// - thermal latch held until standby or restart
// - overcurrent masked four chopper ticks, then latched
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module stepper_step_dir_control #(
  parameter int CHOP_DIV = stepper_pkg::CHOP_DIV_CYCLES,
  parameter int ISD_MASK = stepper_pkg::ISD_MASK_TICKS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic step_clock,
  input wire logic rotation_direction,
  input wire logic output_enable,
  input wire logic angle_reset,
  input wire logic resolution_sel_0,
  input wire logic resolution_sel_1,
  input wire logic resolution_sel_2,
  input wire logic thermal_trip,
  input wire logic overcurrent_trip,
  input wire logic fault_pin_i,
  output logic fault_pin_o,
  output logic fault_pin_oe,
  output logic [7:0] phase_a_output,
  output logic phase_a_negative,
  output logic phase_a_drive_en,
  output logic [7:0] phase_b_output,
  output logic phase_b_negative,
  output logic phase_b_drive_en,
  output logic angle_home_monitor,
  output logic chopper_oscillator,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NSYNC = 10;

  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic step_prev_reg;
  logic step_rise;
  logic [2:0] sel_code;
  logic pin_standby;
  logic standby;
  stepper_pkg::step_mode_t mode;
  logic [6:0] step_size;
  logic [6:0] angle_reg;
  logic [15:0] chop_cnt_reg;
  logic chop_tick_reg;
  logic [2:0] oc_cnt_reg;
  logic thermal_shutdown_reg;
  logic overcurrent_shutdown_reg;
  logic fault;
  logic drive;
  logic ctrl_standby_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic write_fire;
  logic write_ctrl;
  logic [7:0] ar_word;
  logic [31:0] status_word;

  phase_map_if pm ();

  angle_to_phase u_map (
    .pm(pm.mapper)
  );

  // every pin passes two flops before any logic sees it
  assign pins_raw = {fault_pin_i, overcurrent_trip, thermal_trip,
                     resolution_sel_2, resolution_sel_1, resolution_sel_0,
                     angle_reset, output_enable, rotation_direction,
                     step_clock};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      step_prev_reg <= 1'b0;
    end else begin
      step_prev_reg <= sync2_reg[0];
    end
  end

  // falling edges are ignored
  assign step_rise = sync2_reg[0] & ~step_prev_reg;
  assign sel_code = {sync2_reg[4], sync2_reg[5], sync2_reg[6]};
  assign pin_standby = (sel_code == 3'h0);
  assign standby = pin_standby | ctrl_standby_reg;
  assign fault = thermal_shutdown_reg | overcurrent_shutdown_reg;
  assign drive = sync2_reg[2] & ~standby & ~fault;

  always_comb begin
    unique case (sel_code)
      3'h1: mode = stepper_pkg::MODE_FULL;
      3'h2: mode = stepper_pkg::MODE_HALF_A;
      3'h3: mode = stepper_pkg::MODE_QUARTER;
      3'h4: mode = stepper_pkg::MODE_HALF_B;
      3'h5: mode = stepper_pkg::MODE_EIGHTH;
      3'h6: mode = stepper_pkg::MODE_SIXTEENTH;
      3'h7: mode = stepper_pkg::MODE_THIRTYSECOND;
      // standby keeps the full-step setting
      3'h0: mode = stepper_pkg::MODE_FULL;
    endcase
  end

  always_comb begin
    unique case (mode)
      stepper_pkg::MODE_STANDBY: step_size = 7'h20;
      stepper_pkg::MODE_FULL: step_size = 7'h20;
      stepper_pkg::MODE_HALF_A: step_size = 7'h10;
      stepper_pkg::MODE_HALF_B: step_size = 7'h10;
      stepper_pkg::MODE_QUARTER: step_size = 7'h08;
      stepper_pkg::MODE_EIGHTH: step_size = 7'h04;
      stepper_pkg::MODE_SIXTEENTH: step_size = 7'h02;
      stepper_pkg::MODE_THIRTYSECOND: step_size = 7'h01;
    endcase
  end

  // 128 positions per electrical cycle, wrap is free in 7 bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      angle_reg <= stepper_pkg::HOME_ANGLE;
    end else if (sync2_reg[3]) begin
      angle_reg <= stepper_pkg::HOME_ANGLE;
    end else if (step_rise && !standby && !fault) begin
      if (sync2_reg[1]) begin
        angle_reg <= 7'(angle_reg + step_size);
      end else begin
        angle_reg <= 7'(angle_reg - step_size);
      end
    end
  end

  assign pm.angle = angle_reg;
  assign pm.mode = mode;

  // chopper runs from the core clock; stopped in standby
  always_ff @(posedge core_clk) begin
    if (srst || standby) begin
      chop_cnt_reg <= '0;
      chop_tick_reg <= 1'b0;
    end else if (chop_cnt_reg == 16'(CHOP_DIV - 1)) begin
      chop_cnt_reg <= '0;
      chop_tick_reg <= 1'b1;
    end else begin
      chop_cnt_reg <= 16'(chop_cnt_reg + 16'h1);
      chop_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      chopper_oscillator <= 1'b0;
    end else begin
      chopper_oscillator <= !standby && (chop_cnt_reg < 16'(CHOP_DIV / 2));
    end
  end

  // a trip still present while standby is selected stays latched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      thermal_shutdown_reg <= 1'b0;
    end else if (sync2_reg[7]) begin
      thermal_shutdown_reg <= 1'b1;
    end else if (pin_standby) begin
      thermal_shutdown_reg <= 1'b0;
    end
  end

  // short spikes from switching noise never reach the latch
  always_ff @(posedge core_clk) begin
    if (srst || pin_standby) begin
      oc_cnt_reg <= '0;
      overcurrent_shutdown_reg <= 1'b0;
    end else if (!sync2_reg[8]) begin
      oc_cnt_reg <= '0;
    end else if (chop_tick_reg && !overcurrent_shutdown_reg) begin
      oc_cnt_reg <= 3'(oc_cnt_reg + 3'h1);
      if (oc_cnt_reg == 3'(ISD_MASK - 1)) begin
        overcurrent_shutdown_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_a_output <= '0;
      phase_b_output <= '0;
      phase_a_negative <= 1'b0;
      phase_b_negative <= 1'b0;
      phase_a_drive_en <= 1'b0;
      phase_b_drive_en <= 1'b0;
    end else begin
      phase_a_output <= drive ? pm.a_mag : 8'h00;
      phase_b_output <= drive ? pm.b_mag : 8'h00;
      phase_a_negative <= pm.a_neg;
      phase_b_negative <= pm.b_neg;
      phase_a_drive_en <= drive;
      phase_b_drive_en <= drive;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      angle_home_monitor <= 1'b0;
      fault_pin_o <= 1'b0;
      fault_pin_oe <= 1'b0;
    end else begin
      angle_home_monitor <= (angle_reg != stepper_pkg::HOME_ANGLE);
      fault_pin_o <= 1'b0;
      fault_pin_oe <= fault;
    end
  end

  // write channel: address and data taken in either order
  assign write_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign write_ctrl = ({awaddr_reg[7:2], 2'h0} ==
                       stepper_pkg::REG_CTRL_ADDR);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= stepper_pkg::AXI_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (write_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_ctrl ? stepper_pkg::AXI_OKAY :
                       stepper_pkg::AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_standby_reg <= stepper_pkg::CTRL_RESET;
    end else if (write_fire && write_ctrl && wstrb_reg[0]) begin
      ctrl_standby_reg <= wdata_reg[stepper_pkg::CTRL_STANDBY_BIT];
    end
  end

  always_comb begin
    status_word = '0;
    status_word[stepper_pkg::ST_ANGLE_LSB +: 7] = angle_reg;
    status_word[stepper_pkg::ST_MODE_LSB +: 3] = sel_code;
    status_word[stepper_pkg::ST_STANDBY_BIT] = standby;
    status_word[stepper_pkg::ST_THERMAL_BIT] = thermal_shutdown_reg;
    status_word[stepper_pkg::ST_OVERCURRENT_BIT] = overcurrent_shutdown_reg;
    status_word[stepper_pkg::ST_HOME_BIT] =
      (angle_reg == stepper_pkg::HOME_ANGLE);
    status_word[stepper_pkg::ST_FAULT_PIN_BIT] = sync2_reg[9];
  end

  assign ar_word = {s_axi_araddr[7:2], 2'h0};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= stepper_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (ar_word == stepper_pkg::REG_CTRL_ADDR) begin
        s_axi_rdata <= {31'h0, ctrl_standby_reg};
        s_axi_rresp <= stepper_pkg::AXI_OKAY;
      end else if (ar_word == stepper_pkg::REG_STATUS_ADDR) begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= stepper_pkg::AXI_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= stepper_pkg::AXI_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : stepper_step_dir_control

// ### stepper_step_dir_control_checker.sv
`timescale 1ns/1ps
module stepper_step_dir_control_checker #(
  parameter int CHOP_DIV = stepper_pkg::CHOP_DIV_CYCLES,
  parameter int ISD_MASK = stepper_pkg::ISD_MASK_TICKS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic output_enable,
  input wire logic angle_reset,
  input wire logic resolution_sel_0,
  input wire logic resolution_sel_1,
  input wire logic resolution_sel_2,
  input wire logic thermal_trip,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe,
  input wire logic [7:0] phase_a_output,
  input wire logic [7:0] phase_b_output,
  input wire logic phase_a_negative,
  input wire logic phase_b_negative,
  input wire logic phase_a_drive_en,
  input wire logic phase_b_drive_en,
  input wire logic angle_home_monitor,
  input wire logic chopper_oscillator
);
  wire sel_any = resolution_sel_0 | resolution_sel_1 | resolution_sel_2;
  wire drive_any = phase_a_drive_en | phase_b_drive_en;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  chk_od_sink: assert property (fault_pin_o == 1'h0)
    else $error("fault pin driven high");
  chk_enable_off: assert property (!output_enable [*4] |=> !drive_any)
    else $error("bridge on with enable low");
  // magnitude and bridge enable leave the same flop stage together
  chk_idle_zero: assert property (
    !drive_any |-> phase_a_output == 8'h00 && phase_b_output == 8'h00)
    else $error("idle phase not zero");
  chk_standby_off: assert property (!sel_any [*4] |=>
    !drive_any && !chopper_oscillator) else $error("standby not off");
  chk_thermal_flag: assert property (thermal_trip [*5] |=>
    fault_pin_oe && !drive_any) else $error("thermal not flagged");
  chk_latch_hold: assert property (sel_any [*4] ##0 fault_pin_oe |=>
    fault_pin_oe) else $error("fault latch dropped");
  chk_fault_blocks: assert property (fault_pin_oe |-> !drive_any)
    else $error("bridge on during fault");
  chk_reset_home: assert property (angle_reset [*5] |=>
    !angle_home_monitor) else $error("angle reset not home");
  chk_home_equal: assert property (
    !angle_home_monitor && phase_a_drive_en |-> phase_a_output ==
    phase_b_output && phase_a_output inside {8'hFF, 8'hB4} &&
    !phase_a_negative && !phase_b_negative) else $error("home current bad");
endmodule : stepper_step_dir_control_checker

bind stepper_step_dir_control stepper_step_dir_control_checker #(
  .CHOP_DIV(CHOP_DIV), .ISD_MASK(ISD_MASK)) u_chk (
  .core_clk, .srst, .output_enable, .angle_reset, .resolution_sel_0,
  .resolution_sel_1, .resolution_sel_2, .thermal_trip, .fault_pin_o,
  .fault_pin_oe, .phase_a_output, .phase_b_output, .phase_a_negative,
  .phase_b_negative, .phase_a_drive_en, .phase_b_drive_en,
  .angle_home_monitor, .chopper_oscillator);

// ### step_host.sv
`timescale 1ns/1ps
module step_host #(
  // the rated step limit is the host's duty; this bench runs far above
  // it on purpose to keep runs short, the block has no limit of its own
  parameter int HALF_NS = 32
) (
  output logic step_clock
);
  // pin rests low between bursts, never free-running
  initial step_clock = 1'h0;
  task automatic pulse(input int n);
    repeat (n) begin
      #(HALF_NS) step_clock = 1'h1;
      #(HALF_NS) step_clock = 1'h0;
    end
  endtask : pulse
endmodule : step_host

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'h0, srst = 1'h1, rotation_direction = 1'h1;
  logic output_enable = 1'h0, angle_reset = 1'h0, thermal_trip = 1'h0;
  logic overcurrent_trip = 1'h0, resolution_sel_0 = 1'h0;
  logic resolution_sel_1 = 1'h0, resolution_sel_2 = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire step_clock;
  logic fault_pin_o, fault_pin_oe, phase_a_negative, phase_b_negative;
  logic phase_a_drive_en, phase_b_drive_en, angle_home_monitor;
  logic chopper_oscillator, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] phase_a_output, phase_b_output;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0;
  int num_checks = 0;
  // steps per electrical cycle for each select code
  int cnt[8] = '{0, 4, 8, 16, 8, 32, 64, 128};
  localparam int CHOP = 8;
  // open-drain fault wire with its pull-up
  wire fault_pin_i = fault_pin_oe ? fault_pin_o : 1'h1;

  always #2.5 core_clk = ~core_clk;

  step_host u_host (.step_clock);
  // short chopper divider keeps the overcurrent mask test brief
  stepper_step_dir_control #(.CHOP_DIV(CHOP)) u_dut (
    .core_clk, .srst, .step_clock, .rotation_direction, .output_enable,
    .angle_reset, .resolution_sel_0, .resolution_sel_1, .resolution_sel_2,
    .thermal_trip, .overcurrent_trip, .fault_pin_i, .fault_pin_o,
    .fault_pin_oe, .phase_a_output, .phase_a_negative, .phase_a_drive_en,
    .phase_b_output, .phase_b_negative, .phase_b_drive_en,
    .angle_home_monitor, .chopper_oscillator, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk

  task automatic set_mode(input logic [2:0] m);
    {resolution_sel_0, resolution_sel_1, resolution_sel_2} <= m;
    wait_clk(10);
  endtask : set_mode

  task automatic step(input int n);
    u_host.pulse(n);
    wait_clk(8);
  endtask : step

  task automatic check_out(input logic [7:0] mag, input logic [2:0] f);
    check({phase_a_output, phase_b_output, phase_a_negative,
      phase_b_negative, angle_home_monitor}, {mag, mag, f});
  endtask : check_out

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    wait_clk(1);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    wait_clk(1);
  endtask : axi_read

  initial begin
    logic [7:0] m;
    logic [31:0] d;
    logic [1:0] r;
    wait_clk(8);
    srst <= 1'h0;
    set_mode(3'h1);
    output_enable <= 1'h1;
    wait_clk(8);
    for (int i = 1; i < 8; i++) begin
      m = (i inside {1, 2, 4}) ? 8'hFF : 8'hB4;
      angle_reset <= 1'h1;
      set_mode(i[2:0]);
      check_out(m, 3'h0);
      angle_reset <= 1'h0;
      step(cnt[i] - 1);
      check(angle_home_monitor, 1'h1);
      step(1);
      check_out(m, 3'h0);
    end
    $display("test resolution done");
    axi_read(8'h04, d, r);
    check({r, d}, {2'h0, 32'h0000C710});
    axi_write(8'h00, 32'h1, r);
    wait_clk(8);
    check({r, phase_a_drive_en}, 3'h0);
    axi_write(8'h00, 32'h0, r);
    wait_clk(8);
    check({r, phase_a_drive_en}, 3'h1);
    axi_write(8'h04, 32'h0, r);
    check(r, 2'h2);
    axi_read(8'h08, d, r);
    check({r, d}, {2'h2, 32'h0});
    $display("test registers done");
    angle_reset <= 1'h1;
    set_mode(3'h1);
    angle_reset <= 1'h0;
    step(1);
    check_out(8'hFF, 3'h5);
    rotation_direction <= 1'h0;
    step(2);
    check_out(8'hFF, 3'h3);
    output_enable <= 1'h0;
    wait_clk(8);
    check({phase_a_drive_en, phase_b_drive_en, phase_a_output}, 0);
    output_enable <= 1'h1;
    wait_clk(8);
    check({phase_a_drive_en, phase_b_drive_en}, 2'h3);
    // outside standby the chopper runs at half duty
    m = 8'h00;
    for (int k = 0; k < CHOP; k++) begin
      m = 8'(m + 8'(chopper_oscillator));
      wait_clk(1);
    end
    check(m, 8'(CHOP / 2));
    $display("test direction done");
    thermal_trip <= 1'h1;
    wait_clk(8);
    check({fault_pin_oe, fault_pin_i, phase_a_drive_en}, 3'h4);
    thermal_trip <= 1'h0;
    wait_clk(8);
    check({fault_pin_oe, phase_b_drive_en}, 2'h2);
    set_mode(3'h0);
    set_mode(3'h1);
    check({fault_pin_oe, fault_pin_i, phase_a_drive_en}, 3'h3);
    // two chopper ticks only: shorter than the mask
    overcurrent_trip <= 1'h1;
    wait_clk(16);
    overcurrent_trip <= 1'h0;
    wait_clk(40);
    check(fault_pin_oe, 1'h0);
    overcurrent_trip <= 1'h1;
    wait_clk(80);
    overcurrent_trip <= 1'h0;
    wait_clk(40);
    check({fault_pin_oe, phase_a_drive_en}, 2'h2);
    set_mode(3'h0);
    for (int k = 0; k < 12; k++) begin
      check({chopper_oscillator, phase_a_drive_en, fault_pin_oe}, 0);
      wait_clk(1);
    end
    $display("test faults done");
    finish_test();
  end

  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule : tb
